// ==== garl_pkg.sv ====
// Purpose: Constants and types for the gas alarm relay logic
// Assumes: Measured values and thresholds share one unsigned fixed-point scale
// Notes: Flow in 0.01 L/min units, oxygen in 0.01 vol% units
package garl_pkg;
  localparam int VAL_W = 16;
  localparam int FLOW_W = 8;
  // Flow thresholds, 0.01 L/min per count
  localparam logic [FLOW_W-1:0] FLOW_ERR_LIM = 8'h1e;
  localparam logic [FLOW_W-1:0] FLOW_NOTE_LIM = 8'h28;
  // Oxygen threshold window, 0.01 vol% per count
  localparam logic [VAL_W-1:0] O2_MIN_THR = 16'h000a;
  localparam logic [VAL_W-1:0] O2_MAX_THR = 16'h09c4;
  localparam logic [VAL_W-1:0] THR_RST = 16'hffff;
  localparam logic [VAL_W-1:0] HYS_RST = 16'h0000;
  localparam logic CFG_RST = 1'b0;
  localparam logic RELAY_RST = 1'b0;

  typedef enum logic [2:0] {
    GARL_IDLE = 3'b001,
    GARL_ACTIVE = 3'b010,
    GARL_HELD = 3'b100
  } garl_state_t;
endpackage : garl_pkg

// ==== garl_sync.sv ====
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Input comes from outside the clk domain
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module garl_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : garl_sync

// ==== garl_chan.sv ====
// Purpose: One alarm channel: compare, hysteresis, latch and acknowledge
// Assumes: sample_vld marks a new measured value
// Notes: Threshold outside the oxygen window is refused in oxygen mode
`timescale 1ns/1ps
module garl_chan
  import garl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic sample_vld,
  input wire logic [garl_pkg::VAL_W-1:0] value,
  input wire logic [garl_pkg::VAL_W-1:0] thr_in,
  input wire logic thr_wr,
  input wire logic o2_mode,
  input wire logic [garl_pkg::VAL_W-1:0] hys,
  input wire logic dir_fall,
  input wire logic latching,
  input wire logic ack_any,
  input wire logic ack,
  output logic alarm,
  output logic cond,
  output logic [garl_pkg::VAL_W-1:0] thr
);
  garl_state_t st_reg, st_next;
  logic cond_reg;
  logic [VAL_W-1:0] thr_reg;
  logic [VAL_W:0] up_lim, lo_lim;
  logic trip, clear, cond_now, thr_ok;
  // Marks a hold entered by an accepted acknowledge, so ceasing does not re-arm the relay
  logic acked_reg, acked_next;

  assign thr_ok = !o2_mode || (thr_in >= O2_MIN_THR && thr_in <= O2_MAX_THR);
  assign up_lim = {1'b0, thr_reg} + {1'b0, hys};
  assign lo_lim = ({1'b0, thr_reg} >= {1'b0, hys}) ? {1'b0, thr_reg} - {1'b0, hys} : '0;
  assign trip = dir_fall ? (value < thr_reg) : (value > thr_reg);
  // Release only past threshold by hysteresis, avoids chatter
  assign clear = dir_fall ? ({1'b0, value} >= up_lim) : ({1'b0, value} < lo_lim);
  assign cond_now = cond_reg ? !clear : trip;
  assign acked_next = (st_next == GARL_HELD)
                      && ((st_reg == GARL_ACTIVE) ? (ack && ack_any) : acked_reg);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      GARL_IDLE: if (cond_now) st_next = GARL_ACTIVE;
      GARL_ACTIVE: begin
        if (ack && ack_any) st_next = cond_now ? GARL_HELD : GARL_IDLE;
        else if (!cond_now) st_next = latching ? GARL_HELD : GARL_IDLE;
      end
      GARL_HELD: begin
        // Held covers acked-but-present and latched-after-cease
        if (!cond_now && (ack || !latching || acked_reg)) st_next = GARL_IDLE;
        else if (cond_now && !acked_reg) st_next = GARL_ACTIVE;
      end
      default: st_next = GARL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= GARL_IDLE;
      cond_reg <= 1'b0;
      acked_reg <= 1'b0;
      thr_reg <= THR_RST;
    end else if (ce) begin
      if (thr_wr && thr_ok) thr_reg <= thr_in;
      if (sample_vld) begin
        st_reg <= st_next;
        cond_reg <= cond_now;
        acked_reg <= acked_next;
      end
    end
  end

  // Acked-while-present holds relay off; latched-after-cease keeps it on
  assign alarm = (st_reg == GARL_ACTIVE) || (st_reg == GARL_HELD && !cond_reg && !acked_reg);
  assign cond = cond_reg;
  assign thr = thr_reg;
endmodule : garl_chan

// ==== garl_top.sv ====
// Purpose: Alarm relay decision logic with two alarm channels
// Assumes: Configuration bits are plain ports on clk; key and pump pins are async
// Notes: Relay outputs registered, updated one cycle after a sample
`timescale 1ns/1ps
//
// Contract
// - Alarm disable drops alarm relays, hides reports, activates fault relay.
// - Fail-safe polarity: coil powered idle, unpowered in alarm.
// - Alarm-driven polarity: coil powered only while alarm active.
// - Rising direction alarms when value exceeds threshold.
// - Falling direction alarms when value drops under threshold.
// - Latching holds relay after condition ends until acknowledged.
// - Non-latching returns relay to idle when condition ends.
// - Acknowledging mode releases relay even while condition present.
// - Non-acknowledging mode honours acknowledge only after condition ends.
// - Hysteresis keeps alarm until value passes threshold by that amount.
// - Key acknowledge disabled plus latching: only reset clears alarm.
// - Relay test simulates pre, main or fault until disabled.
// - Two independent channels, pre-alarm and main alarm.
// - Pump adjust drives maintenance signal and fault relay if fitted.
// - Flow error below 0.3 L/min, notice below 0.4 L/min.
// - Oxygen thresholds accepted only from 0.1 to 25 vol%.
module garl_top
  import garl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic sample_vld,
  input wire logic [garl_pkg::VAL_W-1:0] value,
  input wire logic o2_mode,
  input wire logic alarm_en,
  input wire logic fail_safe,
  input wire logic key_ack_en,
  input wire logic ack_key_pin,
  input wire logic relay_fitted,
  input wire logic pump_adj_pin,
  input wire logic [garl_pkg::FLOW_W-1:0] flow,
  input wire logic dev_fault,
  input wire logic test_pre,
  input wire logic test_main,
  input wire logic test_fault,
  input wire logic [garl_pkg::VAL_W-1:0] pre_thr_in,
  input wire logic pre_thr_wr,
  input wire logic [garl_pkg::VAL_W-1:0] pre_hys,
  input wire logic pre_dir_fall,
  input wire logic pre_latching,
  input wire logic pre_ack_any,
  input wire logic [garl_pkg::VAL_W-1:0] main_thr_in,
  input wire logic main_thr_wr,
  input wire logic [garl_pkg::VAL_W-1:0] main_hys,
  input wire logic main_dir_fall,
  input wire logic main_latching,
  input wire logic main_ack_any,
  output logic pre_alarm_coil,
  output logic main_alarm_coil,
  output logic fault_coil,
  output logic pre_alarm,
  output logic main_alarm,
  output logic maint_signal,
  output logic flow_error,
  output logic flow_notice
);
  logic ack_key_s, pump_adj_s, ack_key_d_reg, ack_pulse;
  logic pre_st, main_st, pre_c, main_c;
  logic pre_act, main_act, fault_act;
  logic pre_alarm_coil_next, main_alarm_coil_next, fault_coil_next;

  garl_sync u_ack_sync (.clk(clk), .sys_rst(sys_rst), .ce(ce), .d(ack_key_pin), .q(ack_key_s));
  garl_sync u_pump_sync (.clk(clk), .sys_rst(sys_rst), .ce(ce), .d(pump_adj_pin), .q(pump_adj_s));

  // Key press edge, gated: disabled key leaves latched alarms until reset
  assign ack_pulse = ack_key_s && !ack_key_d_reg && key_ack_en;

  garl_chan u_pre (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .sample_vld(sample_vld), .value(value),
    .thr_in(pre_thr_in), .thr_wr(pre_thr_wr), .o2_mode(o2_mode), .hys(pre_hys),
    .dir_fall(pre_dir_fall), .latching(pre_latching), .ack_any(pre_ack_any),
    .ack(ack_pulse), .alarm(pre_st), .cond(pre_c), .thr()
  );
  garl_chan u_main (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .sample_vld(sample_vld), .value(value),
    .thr_in(main_thr_in), .thr_wr(main_thr_wr), .o2_mode(o2_mode), .hys(main_hys),
    .dir_fall(main_dir_fall), .latching(main_latching), .ack_any(main_ack_any),
    .ack(ack_pulse), .alarm(main_st), .cond(main_c), .thr()
  );

  assign pre_act = (pre_st && alarm_en) || test_pre;
  assign main_act = (main_st && alarm_en) || test_main;
  // Fault relay also flags disabled alarms and pump adjustment
  assign fault_act = dev_fault || test_fault || !alarm_en
                     || (pump_adj_s && relay_fitted);
  assign pre_alarm_coil_next = fail_safe ? !pre_act : pre_act;
  assign main_alarm_coil_next = fail_safe ? !main_act : main_act;
  assign fault_coil_next = fail_safe ? !fault_act : fault_act;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_key_d_reg <= 1'b0;
      pre_alarm_coil <= RELAY_RST;
      main_alarm_coil <= RELAY_RST;
      fault_coil <= RELAY_RST;
      pre_alarm <= 1'b0;
      main_alarm <= 1'b0;
      maint_signal <= 1'b0;
      flow_error <= 1'b0;
      flow_notice <= 1'b0;
    end else if (ce) begin
      ack_key_d_reg <= ack_key_s;
      pre_alarm_coil <= pre_alarm_coil_next;
      main_alarm_coil <= main_alarm_coil_next;
      fault_coil <= fault_coil_next;
      pre_alarm <= pre_act;
      main_alarm <= main_act;
      maint_signal <= pump_adj_s;
      // Flow supervision suspended during adjustment
      flow_error <= !pump_adj_s && (flow < FLOW_ERR_LIM);
      flow_notice <= !pump_adj_s && (flow < FLOW_NOTE_LIM);
    end
  end

  property p_dis_fault;
    @(posedge clk) disable iff (sys_rst) (ce && !alarm_en) |=> (fault_coil != $past(fail_safe));
  endproperty
  a_dis_fault: assert property (p_dis_fault) else $error("fault relay not set when disabled");

  property p_dis_quiet;
    @(posedge clk) disable iff (sys_rst)
      (ce && !alarm_en && !test_pre && !test_main) |=> (!pre_alarm && !main_alarm);
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("alarm reported while disabled");

  property p_failsafe;
    @(posedge clk) disable iff (sys_rst) (ce && fail_safe) |=> (pre_alarm_coil == !pre_alarm);
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("fail-safe coil wrong");

  property p_alarm_drv;
    @(posedge clk) disable iff (sys_rst)
      (ce && !fail_safe) |=> (main_alarm_coil == main_alarm);
  endproperty
  a_alarm_drv: assert property (p_alarm_drv) else $error("alarm-driven coil wrong");

  property p_test;
    @(posedge clk) disable iff (sys_rst) (ce && test_pre) |=> pre_alarm;
  endproperty
  a_test: assert property (p_test) else $error("relay test not simulated");

  property p_pump;
    @(posedge clk) disable iff (sys_rst)
      (ce && pump_adj_s && relay_fitted) |=> (maint_signal && fault_coil != $past(fail_safe));
  endproperty
  a_pump: assert property (p_pump) else $error("pump adjust outputs wrong");

  property p_flow;
    @(posedge clk) disable iff (sys_rst)
      (ce && !pump_adj_s && flow == 8'h1d) |=> (flow_error && flow_notice);
  endproperty
  a_flow: assert property (p_flow) else $error("flow error threshold wrong");

  property p_flow_n;
    @(posedge clk) disable iff (sys_rst)
      (ce && !pump_adj_s && flow == 8'h27) |=> (!flow_error && flow_notice);
  endproperty
  a_flow_n: assert property (p_flow_n) else $error("flow notice threshold wrong");

  property p_nokey;
    @(posedge clk) disable iff (sys_rst)
      (ce && !key_ack_en) |-> !ack_pulse;
  endproperty
  a_nokey: assert property (p_nokey) else $error("key acknowledge while disabled");

  property p_rise;
    @(posedge clk) disable iff (sys_rst)
      (ce && sample_vld && !pre_dir_fall && value > u_pre.thr_reg && !pre_c)
        |=> (ce |-> pre_c);
  endproperty
  a_rise: assert property (p_rise) else $error("rising alarm missed");
endmodule : garl_top

// ==== garl_relay_mdl.sv ====
// Purpose: Relay bank model driven by the coil outputs of the alarm logic
// Assumes: Coil high means current flows through the relay coil
// Notes: Contacts are seen one clock after the coil changes
`timescale 1ns/1ps
module garl_relay_mdl (
  input wire logic clk,
  input wire logic [2:0] coil,
  output logic [2:0] closed
);
  // A real armature is slow; one clock of lag stands in for it
  always_ff @(posedge clk) begin
    closed <= coil;
  end
endmodule : garl_relay_mdl

// ==== tb.sv ====
// Purpose: Self-checking bench for the gas alarm relay logic
// Assumes: Inputs change on the falling clock edge
// Notes: Samples come from a fixed-seed LFSR placed around both thresholds
`timescale 1ns/1ps
module tb;
  import garl_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, vld = 1'b0, o2_mode = 1'b0, en = 1'b1, fs = 1'b0;
  logic kae = 1'b1, key = 1'b0, pump = 1'b0, wr = 1'b0, mf = 1'b1, ml = 1'b0, ma = 1'b0;
  logic ce = 1'b1;
  logic [FLOW_W-1:0] flow = 8'h50;
  logic [2:0] tst = 3'b000;
  logic [2:0] closed;
  logic [VAL_W-1:0] value = 16'h0000, pthr = 16'h0100, mthr = 16'h0200;
  logic [VAL_W-1:0] pre_hys = 16'h0010, mhys = 16'h0008, v, lfsr = 16'hf18a;
  logic pc, mc, fc, pal, mal, mnt, fe, fn, pe = 1'b0, me = 1'b0;
  logic [7:0] fv [4] = '{8'h1d, 8'h1e, 8'h27, 8'h28};
  // Value, key press, key enable, ack mode, expected main alarm
  logic [19:0] stp [8] = '{20'h03005, 20'h0300d, 20'h01005, 20'h01009, 20'h0100c,
    20'h03007, 20'h0300e, 20'h01006};
  int err_count = 0;
  int tests_run = 0;

  garl_top u_garl_top (
    .clk, .sys_rst, .ce(ce), .sample_vld(vld), .value, .o2_mode, .alarm_en(en),
    .fail_safe(fs), .key_ack_en(kae), .ack_key_pin(key), .relay_fitted(1'b1),
    .pump_adj_pin(pump), .flow, .dev_fault(1'b0), .test_pre(tst[0]),
    .test_main(tst[1]), .test_fault(tst[2]), .pre_thr_in(pthr), .pre_thr_wr(wr),
    .pre_hys, .pre_dir_fall(1'b0), .pre_latching(ml), .pre_ack_any(1'b0),
    .main_thr_in(mthr), .main_thr_wr(wr), .main_hys(mhys), .main_dir_fall(mf),
    .main_latching(ml), .main_ack_any(ma), .pre_alarm_coil(pc), .main_alarm_coil(mc),
    .fault_coil(fc), .pre_alarm(pal), .main_alarm(mal), .maint_signal(mnt),
    .flow_error(fe), .flow_notice(fn)
  );
  garl_relay_mdl u_garl_relay_mdl (
    .clk,
    .coil({fc, mc, pc}),
    .closed
  );

  always #2.5 clk = ~clk;

  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx

  // Non-latching channel state after one sample
  function automatic logic nxt(logic a, logic [15:0] x, logic [15:0] t, logic [15:0] h,
                               logic f);
    if (!a) return f ? (x < t) : (x > t);
    return f ? (x < t + h) : (x >= t - h);
  endfunction : nxt

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Sample held long enough for a key press to cross the synchroniser
  task automatic smp(logic [15:0] x, logic k);
    value = x;
    key = k;
    vld = 1'b1;
    cyc(7);
    vld = 1'b0;
    key = 1'b0;
    cyc(3);
  endtask : smp

  task automatic load;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask : load

  task automatic rst_pulse;
    sys_rst = 1'b1;
    cyc(1);
    sys_rst = 1'b0;
  endtask : rst_pulse

  task automatic final_report;
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Whole run is under 1000 cycles; four times that means a hang
  initial begin
    #20000;
    err_count++;
    final_report();
  end

  initial begin
    cyc(10);
    sys_rst = 1'b0;
    cyc(2);
    chk({pc, mc, fc, pal, mal, mnt}, 16'h0000);
    load();
    for (int i = 0; i < 40; i++) begin
      lfsr = nx(lfsr);
      v = (i[0] ? 16'h01e0 : 16'h00e8) + (lfsr & 16'h003f);
      fs = (i >= 20);
      pe = nxt(pe, v, pthr, pre_hys, 1'b0);
      me = nxt(me, v, mthr, mhys, 1'b1);
      smp(v, 1'b0);
      chk({pal, mal}, {pe, me});
      chk({pc, mc}, {fs, fs} ^ {pe, me});
    end
    fs = 1'b0;
    rst_pulse();
    mf = 1'b0;
    ml = 1'b1;
    mhys = 16'h0000;
    load();
    foreach (stp[i]) begin
      {kae, ma} = stp[i][2:1];
      smp(stp[i][19:4], stp[i][3]);
      chk(mal, stp[i][0]);
    end
    en = 1'b0;
    smp(16'h0300, 1'b0);
    chk({pal, mal, pc, mc, fc}, 5'b00001);
    en = 1'b1;
    ml = 1'b0;
    rst_pulse();
    o2_mode = 1'b1;
    pthr = 16'h0005;
    load();
    smp(16'h0050, 1'b0);
    chk(pal, 1'b0);
    pthr = 16'h0020;
    load();
    smp(16'h0050, 1'b0);
    chk(pal, 1'b1);
    smp(16'h0000, 1'b0);
    o2_mode = 1'b0;
    for (int i = 0; i < 3; i++) begin
      tst = 3'b001 << i;
      cyc(3);
      chk(closed, tst);
    end
    tst = 3'b000;
    for (int i = 0; i < 4; i++) begin
      flow = fv[i];
      cyc(3);
      chk({fe, fn}, {fv[i] < FLOW_ERR_LIM, fv[i] < FLOW_NOTE_LIM});
    end
    pump = 1'b1;
    cyc(6);
    chk({mnt, fc}, 2'b11);
    pump = 1'b0;
    cyc(6);
    chk({mnt, fc, closed}, 5'b00000);
    // Clock enable low must freeze the coils
    ce = 1'b0;
    tst = 3'b001;
    cyc(3);
    chk(closed, 3'b000);
    ce = 1'b1;
    cyc(3);
    chk(closed, 3'b001);
    tst = 3'b000;
    final_report();
  end
endmodule : tb
